// ===== verilog/mmx_pkg.sv
// Shared constants and types for the multiplexer switch control block
`default_nettype none
package mmx_pkg;
   // Channel geometry
   localparam int          BANK_SIZE      = 10;
   localparam int          TREE_SIZE      = 2;
   localparam int          IDX_W          = 4;
   localparam int          CH_W           = 7;
   // Control channel numbers
   localparam logic [6:0]  CH_RELAY       = 7'h5A;
   localparam logic [6:0]  CH_SENSE_BANK  = 7'h5B;
   localparam logic [6:0]  CH_SENSE_THERM = 7'h5C;
   localparam logic [6:0]  CH_SRC_THERM   = 7'h5D;
   localparam logic [6:0]  CH_SRC_BANK    = 7'h5E;
   // Position of each path inside a tree group
   localparam logic [3:0]  TREE_IDX_BANK  = 4'h0;
   localparam logic [3:0]  TREE_IDX_THERM = 4'h1;
   // Values after reset
   localparam logic        SW_RST         = 1'h0;
   localparam logic        READY_RST      = 1'h1;

   // Three conductors of one switch, driven as one
   typedef struct packed {
      logic high;
      logic low;
      logic guard;
   } mmx_sw_type;

   // One open or close request from the mainframe
   typedef struct packed {
      logic       close;
      logic [6:0] chan;
   } mmx_cmd_type;

   typedef enum logic [0:0] {
      MMX_IDLE,
      MMX_MAKE
   } mmx_state_type;
endpackage
`default_nettype wire

// ===== verilog/mmx_excl_group.sv
// One group of mutually exclusive switches (a bank or a tree pair)
`timescale 1ns/1ps
`default_nettype none
module mmx_excl_group #(
   parameter int N = 10
) (
   // Clock and reset
   input  wire logic                         clk_sys_in,
   input  wire logic                         rst_n_in,
   // Control
   input  wire logic                         clear_in,
   input  wire logic                         close_in,
   input  wire logic                         open_in,
   input  wire logic [3:0]                   idx_in,
   // Switch drive
   output var  mmx_pkg::mmx_sw_type [N-1:0]  sw_out
);
   // Index is four bits wide, so sixteen switches at the most
   if (N < 1 || N > 16)
   begin : gen_n_check
      $error("mmx_excl_group: N must be 1 to 16");
   end

   logic       lines_ok;
   logic [N-1:0] sel;

   // All three conductor bits of a switch are written with the same value
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
         sw_out <= '0;                                   // RULE14
      else if (clear_in)
         sw_out <= '0;
      else if (close_in && (32'(idx_in) < N))
      begin
         // Writing the whole group keeps at most one switch closed
         for (int i = 0; i < N; i++)
            sw_out[i] <= (i == 32'(idx_in)) ? 3'h7 : 3'h0; // RULE3 RULE4
      end
      else if (open_in && (32'(idx_in) < N))
         sw_out[idx_in] <= 3'h0;
   end

   // Helper views for checking
   always_comb
   begin
      lines_ok = 1'h1;
      for (int i = 0; i < N; i++)
      begin
         sel[i] = sw_out[i].high;
         if (sw_out[i].low != sw_out[i].high || sw_out[i].guard != sw_out[i].high)
            lines_ok = 1'h0;
      end
   end

   a_one_closed: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE3
      $onehot0(sel)) else $error("two switches closed in one group");
   a_lines_together: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE4
      lines_ok) else $error("switch conductors disagree");
endmodule
`default_nettype wire

// ===== verilog/mmx_switch_ctrl.sv
// Top of the multiplexer switch control: command decode and sequencing
//
// Overview of operation
// RULE1: Twenty switches in two separately exclusive banks.
// RULE2: Channels 0-9 first bank, 10-19 second.
// RULE3: One closed per bank; close opens previous.
// RULE4: High, low, guard switch together always.
// RULE5: Channel 90 opens or closes isolation relays.
// RULE6: Channel 91 sense tree, 94 source tree.
// RULE7: Channels 92, 93 route the reference thermistor.
// RULE8: One tree switch per type closed.
// RULE9: Overvoltage flag opens isolation relays automatically.
// RULE10: Banks reach backplane only via tree.
// RULE11: Source trees carry current, sense trees voltage.
// RULE12: Second bank terminals 0-9 are channels 10-19.
// RULE13: Break before make when changing channels.
// RULE14: Everything open after reset.
`timescale 1ns/1ps
`default_nettype none
module mmx_switch_ctrl #(
   parameter int BANK_N = mmx_pkg::BANK_SIZE
) (
   // Clock and reset
   input  wire logic                              clk_sys_in,
   input  wire logic                              rst_n_in,
   // Command from the mainframe
   input  wire logic                              cmd_valid_in,
   input  wire mmx_pkg::mmx_cmd_type              cmd_in,
   output var  logic                              cmd_ready_out,
   output var  logic                              cmd_err_out,
   // Backplane overvoltage flag
   input  wire logic                              ovp_in,
   // Bank switches
   output wire mmx_pkg::mmx_sw_type [BANK_N-1:0]  bank_a_sw_out,
   output wire mmx_pkg::mmx_sw_type [BANK_N-1:0]  bank_b_sw_out,
   // Tree switches, index 0 banks, index 1 thermistor
   output wire mmx_pkg::mmx_sw_type [1:0]         sense_tree_sw_out,
   output wire mmx_pkg::mmx_sw_type [1:0]         src_tree_sw_out,
   // Isolation relays and routing status
   output var  logic                              relay_out,
   output var  logic                              bank_on_bus_out
);
   // Channel decode serves at most ten switches per bank
   if (BANK_N < 1 || BANK_N > 10)
   begin : gen_bank_n_check
      $error("mmx_switch_ctrl: BANK_N must be 1 to 10");
   end

   mmx_pkg::mmx_state_type state;
   mmx_pkg::mmx_state_type next_state;
   mmx_pkg::mmx_cmd_type   pend;
   mmx_pkg::mmx_cmd_type   cur;
   logic                   accept;
   logic                   valid_chan;
   logic [6:0]             chan_b;
   logic [3:0]             hit;
   logic [3:0]             any_closed;
   logic [3:0]             is_set;
   logic [3:0]             grp_idx [4];
   logic [3:0]             grp_clear;
   logic [3:0]             grp_close;
   logic [3:0]             grp_open;
   logic                   need_break;
   logic [BANK_N-1:0]      sel_a;
   logic [BANK_N-1:0]      sel_b;
   logic [1:0]             sel_s;
   logic [1:0]             sel_c;

   assign accept = cmd_valid_in && cmd_ready_out;

   // Closed-state views of every group
   always_comb
   begin
      for (int i = 0; i < BANK_N; i++)
      begin
         sel_a[i] = bank_a_sw_out[i].high;
         sel_b[i] = bank_b_sw_out[i].high;
      end
      for (int i = 0; i < 2; i++)
      begin
         sel_s[i] = sense_tree_sw_out[i].high;
         sel_c[i] = src_tree_sw_out[i].high;
      end
   end

   // Decode the request in hand: fresh one when idle, held one when making
   always_comb
   begin
      cur = (state == mmx_pkg::MMX_MAKE) ? pend : cmd_in;
      chan_b = cur.chan - 7'(BANK_N);
      hit[0] = (cur.chan < 7'(BANK_N));                                 // RULE2
      hit[1] = (cur.chan >= 7'(BANK_N)) && (cur.chan < 7'(2 * BANK_N)); // RULE2
      hit[2] = (cur.chan == mmx_pkg::CH_SENSE_BANK) ||                  // RULE6
               (cur.chan == mmx_pkg::CH_SENSE_THERM);                   // RULE7
      hit[3] = (cur.chan == mmx_pkg::CH_SRC_BANK) ||                    // RULE6
               (cur.chan == mmx_pkg::CH_SRC_THERM);                     // RULE7
      grp_idx[0] = cur.chan[3:0];
      grp_idx[1] = chan_b[3:0];                                         // RULE12
      grp_idx[2] = (cur.chan == mmx_pkg::CH_SENSE_THERM) ?
                   mmx_pkg::TREE_IDX_THERM : mmx_pkg::TREE_IDX_BANK;
      grp_idx[3] = (cur.chan == mmx_pkg::CH_SRC_THERM) ?
                   mmx_pkg::TREE_IDX_THERM : mmx_pkg::TREE_IDX_BANK;
      valid_chan = (|hit) || (cur.chan == mmx_pkg::CH_RELAY);
      any_closed = {|sel_c, |sel_s, |sel_b, |sel_a};
      is_set[0]  = hit[0] && sel_a[grp_idx[0]];
      is_set[1]  = hit[1] && sel_b[grp_idx[1]];
      is_set[2]  = sel_s[grp_idx[2][0]];
      is_set[3]  = sel_c[grp_idx[3][0]];
   end

   // Per group: open first, then close one cycle later when another is closed
   always_comb
   begin
      grp_clear  = '0;
      grp_close  = '0;
      grp_open   = '0;
      need_break = 1'h0;
      for (int g = 0; g < 4; g++)
      begin
         if (state == mmx_pkg::MMX_MAKE && hit[g])
            grp_close[g] = 1'h1;                                        // RULE13
         else if (state == mmx_pkg::MMX_IDLE && accept && hit[g])
         begin
            if (!cur.close)
               grp_open[g] = 1'h1;
            else if (any_closed[g] && !is_set[g])
            begin
               grp_clear[g] = 1'h1;                                     // RULE3 RULE8 RULE13
               need_break   = 1'h1;
            end
            else if (!is_set[g])
               grp_close[g] = 1'h1;
         end
      end
   end

   // Next state of the sequencer
   always_comb
   begin
      next_state = mmx_pkg::MMX_IDLE;
      unique case (state)
         mmx_pkg::MMX_IDLE:
            next_state = need_break ? mmx_pkg::MMX_MAKE : mmx_pkg::MMX_IDLE;
         mmx_pkg::MMX_MAKE:
            next_state = mmx_pkg::MMX_IDLE;
      endcase
   end

   // Sequencer state, held request and ready
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         state         <= mmx_pkg::MMX_IDLE;
         pend          <= '0;
         cmd_ready_out <= mmx_pkg::READY_RST;
      end
      else
      begin
         state         <= next_state;
         cmd_ready_out <= (next_state == mmx_pkg::MMX_IDLE);
         if (accept)
            pend <= cmd_in;
      end
   end

   // Unknown channel numbers are dropped and flagged for one cycle
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
         cmd_err_out <= 1'h0;
      else
         cmd_err_out <= accept && !valid_chan;
   end

   // Overvoltage overrides any relay command, so a close cannot win against it
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
         relay_out <= mmx_pkg::SW_RST;                                  // RULE14
      else if (ovp_in)
         relay_out <= 1'h0;                                             // RULE9
      else if (accept && cmd_in.chan == mmx_pkg::CH_RELAY)
         relay_out <= cmd_in.close;                                     // RULE5
   end

   // A bank is on the bus only through the closed bank-side sense tree
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
         bank_on_bus_out <= 1'h0;
      else
         bank_on_bus_out <= (|sel_a || |sel_b) && sel_s[0];             // RULE10
   end

   // Two independent banks, each with its own exclusion
   mmx_excl_group #(.N(BANK_N)) u_bank_a (                              // RULE1
      .clk_sys_in (clk_sys_in),
      .rst_n_in   (rst_n_in),
      .clear_in   (grp_clear[0]),
      .close_in   (grp_close[0]),
      .open_in    (grp_open[0]),
      .idx_in     (grp_idx[0]),
      .sw_out     (bank_a_sw_out)
   );
   mmx_excl_group #(.N(BANK_N)) u_bank_b (                              // RULE1
      .clk_sys_in (clk_sys_in),
      .rst_n_in   (rst_n_in),
      .clear_in   (grp_clear[1]),
      .close_in   (grp_close[1]),
      .open_in    (grp_open[1]),
      .idx_in     (grp_idx[1]),
      .sw_out     (bank_b_sw_out)
   );

   // Sense trees carry the voltage lines to the measurement bus
   mmx_excl_group #(.N(mmx_pkg::TREE_SIZE)) u_sense_tree (              // RULE8 RULE11
      .clk_sys_in (clk_sys_in),
      .rst_n_in   (rst_n_in),
      .clear_in   (grp_clear[2]),
      .close_in   (grp_close[2]),
      .open_in    (grp_open[2]),
      .idx_in     (grp_idx[2]),
      .sw_out     (sense_tree_sw_out)
   );
   // Source trees: high carries +I, low carries -I of the current source
   mmx_excl_group #(.N(mmx_pkg::TREE_SIZE)) u_src_tree (                // RULE8 RULE11
      .clk_sys_in (clk_sys_in),
      .rst_n_in   (rst_n_in),
      .clear_in   (grp_clear[3]),
      .close_in   (grp_close[3]),
      .open_in    (grp_open[3]),
      .idx_in     (grp_idx[3]),
      .sw_out     (src_tree_sw_out)
   );

   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_n_in);

   a_relay_cmd: assert property ( // RULE5
      accept && cmd_in.chan == mmx_pkg::CH_RELAY && !ovp_in |=> relay_out == $past(cmd_in.close))
      else $error("relay did not follow command");
   a_ovp_opens: assert property ( // RULE9
      ovp_in |=> !relay_out) else $error("relay closed under overvoltage");
   a_sense_bank: assert property ( // RULE6
      accept && cmd_in.close && cmd_in.chan == mmx_pkg::CH_SENSE_BANK |-> ##[1:2] sel_s[0])
      else $error("bank sense tree not closed");
   a_src_bank: assert property ( // RULE6
      accept && cmd_in.close && cmd_in.chan == mmx_pkg::CH_SRC_BANK |-> ##[1:2] sel_c[0])
      else $error("bank source tree not closed");
   a_therm_trees: assert property ( // RULE7
      accept && cmd_in.close && cmd_in.chan == mmx_pkg::CH_SRC_THERM |-> ##[1:2] sel_c[1])
      else $error("thermistor source tree not closed");
   a_bank_a_map: assert property ( // RULE2
      accept && cmd_in.close && cmd_in.chan == 7'h03 |-> ##[1:2] sel_a[3])
      else $error("channel 3 not in first bank");
   a_bank_b_map: assert property ( // RULE12
      accept && cmd_in.close && cmd_in.chan == 7'h0D |-> ##[1:2] sel_b[3])
      else $error("channel 13 not at second bank terminal 3");
   a_break_first: assert property ( // RULE13
      state == mmx_pkg::MMX_IDLE && grp_clear[0] |=> !(|sel_a) ##1 (|sel_a))
      else $error("bank not opened before close");
   a_bus_path: assert property ( // RULE10
      bank_on_bus_out |-> $past(sel_s[0])) else $error("bank on bus without tree");
   a_reset_open: assert property (@(posedge clk_sys_in) disable iff (1'h0) // RULE14
      !rst_n_in |=> !relay_out && !(|sel_a) && !(|sel_b) && !(|sel_s) && !(|sel_c))
      else $error("switch closed after reset");
   a_reset_idle: assert property (@(posedge clk_sys_in) disable iff (1'h0) // RULE14
      !rst_n_in |=> cmd_ready_out && !cmd_err_out && !bank_on_bus_out)
      else $error("handshake not idle after reset");

   // A request for one bank leaves the other bank untouched
   a_bank_a_alone: assert property ( // RULE1
      accept && hit[0] |=> $stable(sel_b))
      else $error("first bank request moved second bank");
   // Same in the other direction
   a_bank_b_alone: assert property ( // RULE1
      accept && hit[1] |=> $stable(sel_a))
      else $error("second bank request moved first bank");
   // Highest channel lands on the last terminal of the second bank
   a_bank_b_top: assert property ( // RULE12
      accept && cmd_in.close && cmd_in.chan == 7'(2 * BANK_N - 1) |-> ##[1:2] sel_b[BANK_N-1])
      else $error("last channel not at last second bank terminal");
   // Thermistor sense path
   a_sense_therm: assert property ( // RULE7
      accept && cmd_in.close && cmd_in.chan == mmx_pkg::CH_SENSE_THERM |-> ##[1:2] sel_s[1])
      else $error("thermistor sense tree not closed");
   // Seen at the top too, in case a group is wired wrongly
   a_tree_single: assert property ( // RULE8
      $onehot0(sel_s) && $onehot0(sel_c))
      else $error("two tree switches of one type closed");
   // Ready drops for exactly the break cycle
   a_make_gap: assert property ( // RULE13
      state == mmx_pkg::MMX_IDLE && need_break |=> !cmd_ready_out ##1 cmd_ready_out)
      else $error("ready not low for one break cycle");
   // An open takes effect at once, with no break cycle
   a_open_direct: assert property ( // RULE3
      accept && !cmd_in.close && cmd_in.chan == 7'h02 |=> !sel_a[2] && cmd_ready_out)
      else $error("open of channel 2 delayed");
   // Channels outside the decoded ranges flag and move nothing
   a_unknown_chan: assert property ( // RULE2
      accept && ((cmd_in.chan >= 7'(2 * BANK_N) && cmd_in.chan < mmx_pkg::CH_RELAY) ||
                 cmd_in.chan > mmx_pkg::CH_SRC_BANK)
      |=> cmd_err_out && $stable(sel_a) && $stable(sel_b))
      else $error("unknown channel not refused");
endmodule
`default_nettype wire

// ===== dv/mmx_host_model.sv
// Mainframe command source model for the switch control bench
`timescale 1ns/1ps
`default_nettype none
module mmx_host_model (
   // Clock
   input  wire logic                  clk_sys_in,
   // Command handshake
   input  wire logic                  cmd_ready_in,
   output var  logic                  cmd_valid_out,
   output var  mmx_pkg::mmx_cmd_type  cmd_out
);
   // Quiet lines at time zero
   initial
   begin
      cmd_valid_out = 1'h0;
      cmd_out       = 8'h00;
   end

   // One request after gap+1 idle edges, held until the taking edge
   task automatic send(input logic cl, input logic [6:0] ch, input int gap);
      int n;
      // At least one idle edge, so valid never falls and rises in one step
      for (n = 0; n <= gap; n++)
      begin
         @(posedge clk_sys_in);
         #1;
      end
      cmd_valid_out = 1'h1;
      cmd_out       = '{close: cl, chan: ch};
      // A stuck ready is caught by the bench watchdog
      while (cmd_ready_in !== 1'h1)
      begin
         @(posedge clk_sys_in);
         #1;
      end
      @(posedge clk_sys_in);
      #1;
      // Released lines show the inverse, so a stale value is never trusted
      cmd_valid_out = 1'h0;
      cmd_out       = ~cmd_out;
   endtask
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking bench for the multiplexer switch control
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin \
   $display("Error at %0t: got %h expected %h", $time, a, b); error_cnt++; end end
module tb_top;
   logic                              clk_sys_in;
   logic                              rst_n_in;
   logic                              ovp_in;
   logic                              cmd_valid;
   mmx_pkg::mmx_cmd_type              cmd;
   logic                              cmd_ready_out;
   logic                              cmd_err_out;
   mmx_pkg::mmx_sw_type [9:0]         bank_a_sw_out;
   mmx_pkg::mmx_sw_type [9:0]         bank_b_sw_out;
   mmx_pkg::mmx_sw_type [1:0]         sense_tree_sw_out;
   mmx_pkg::mmx_sw_type [1:0]         src_tree_sw_out;
   logic                              relay_out;
   logic                              bank_on_bus_out;
   int                                error_cnt = 0;
   int                                n_tests = 0;

   mmx_switch_ctrl DUT (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid),
      .cmd_in(cmd), .cmd_ready_out(cmd_ready_out), .cmd_err_out(cmd_err_out), .ovp_in(ovp_in),
      .bank_a_sw_out(bank_a_sw_out), .bank_b_sw_out(bank_b_sw_out),
      .sense_tree_sw_out(sense_tree_sw_out), .src_tree_sw_out(src_tree_sw_out),
      .relay_out(relay_out), .bank_on_bus_out(bank_on_bus_out));

   mmx_host_model mf (.clk_sys_in(clk_sys_in), .cmd_ready_in(cmd_ready_out),
      .cmd_valid_out(cmd_valid), .cmd_out(cmd));

   // Free-running 100 MHz clock
   initial clk_sys_in = 1'h0;
   always #5 clk_sys_in = ~clk_sys_in;

   // Expected bank image with switch i closed, or all open for i < 0
   function automatic logic [29:0] sel(input int i);
      sel = 30'h0;
      if (i >= 0) sel[i*3 +: 3] = 3'h7;
   endfunction

   function automatic logic [5:0] tsel(input int i);
      tsel = 6'h0;
      tsel[i*3 +: 3] = 3'h7;
   endfunction

   // Inputs move one nanosecond after the edge
   task automatic step();
      @(posedge clk_sys_in);
      #1;
   endtask

   task automatic test_end(input string name);
      $display("Test %s finished", name);
   endtask

   task automatic reset_and_check();
      rst_n_in = 1'h0;
      repeat (2) step();
      `CHK({bank_a_sw_out, bank_b_sw_out}, 60'h0)
      `CHK({sense_tree_sw_out, src_tree_sw_out, relay_out}, 13'h0)
      `CHK(cmd_ready_out, 1'h1)
      `CHK({cmd_err_out, bank_on_bus_out}, 2'h0)
      rst_n_in = 1'h1;
   endtask

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Watchdog well beyond the fifty or so cycles the tests need
   initial
   begin
      #50000;
      error_cnt++;
      report_and_stop();
   end

   initial
   begin
      rst_n_in = 1'h0;
      ovp_in   = 1'h0;
      step();
      reset_and_check();
      test_end("reset");
      // Bank exclusivity with break before make
      mf.send(1'h1, 7'h03, 0);
      `CHK(bank_a_sw_out, sel(3))
      `CHK(bank_b_sw_out, sel(-1))
      mf.send(1'h1, 7'h02, 0);
      `CHK(bank_a_sw_out, sel(-1))
      `CHK(cmd_ready_out, 1'h0)
      step();
      `CHK(bank_a_sw_out, sel(2))
      mf.send(1'h1, 7'h0D, 0);
      `CHK(bank_b_sw_out, sel(3))
      `CHK(bank_a_sw_out, sel(2))
      mf.send(1'h1, 7'h13, 3);
      step();
      `CHK(bank_b_sw_out, sel(9))
      `CHK(bank_on_bus_out, 1'h0)
      test_end("banks");
      // Tree switches of each type
      mf.send(1'h1, mmx_pkg::CH_SENSE_BANK, 0);
      `CHK(sense_tree_sw_out, tsel(0))
      step();
      `CHK(bank_on_bus_out, 1'h1)
      mf.send(1'h1, mmx_pkg::CH_SRC_BANK, 0);
      `CHK(src_tree_sw_out, tsel(0))
      mf.send(1'h1, mmx_pkg::CH_SENSE_THERM, 0);
      `CHK(sense_tree_sw_out, 6'h0)
      step();
      `CHK(sense_tree_sw_out, tsel(1))
      `CHK(src_tree_sw_out, tsel(0))
      mf.send(1'h1, mmx_pkg::CH_SRC_THERM, 0);
      step();
      `CHK(src_tree_sw_out, tsel(1))
      `CHK(bank_on_bus_out, 1'h0)
      test_end("trees");
      // Isolation relays and overvoltage
      mf.send(1'h1, mmx_pkg::CH_RELAY, 0);
      `CHK(relay_out, 1'h1)
      mf.send(1'h0, mmx_pkg::CH_RELAY, 0);
      `CHK(relay_out, 1'h0)
      mf.send(1'h1, mmx_pkg::CH_RELAY, 0);
      ovp_in = 1'h1;
      step();
      `CHK(relay_out, 1'h0)
      mf.send(1'h1, mmx_pkg::CH_RELAY, 0);
      step();
      `CHK(relay_out, 1'h0)
      ovp_in = 1'h0;
      test_end("relay");
      // Unknown channels are refused and change nothing
      mf.send(1'h1, 7'h14, 0);
      `CHK(cmd_err_out, 1'h1)
      step();
      `CHK(cmd_err_out, 1'h0)
      `CHK(bank_b_sw_out, sel(9))
      mf.send(1'h1, 7'h59, 0);
      `CHK(cmd_err_out, 1'h1)
      `CHK(relay_out, 1'h0)
      mf.send(1'h1, 7'h5F, 0);
      `CHK(cmd_err_out, 1'h1)
      test_end("refused");
      // Open needs no break cycle
      mf.send(1'h0, 7'h02, 0);
      `CHK(bank_a_sw_out, sel(-1))
      `CHK(cmd_ready_out, 1'h1)
      test_end("open");
      // Second reset in mid-run
      step();
      reset_and_check();
      // A close after reset needs no break: nothing is left closed
      mf.send(1'h1, 7'h0D, 0);
      `CHK(bank_b_sw_out, sel(3))
      `CHK(bank_a_sw_out, sel(-1))
      test_end("rereset");
      report_and_stop();
   end
endmodule
`default_nettype wire
